/* File: hdl/wdt_params.svh */
// Constants of the watchdog timer: widths, prescaler ratios and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define WDT_CNT_W      16
`define WDT_PRE_W      14

// ****************************************************************
// Prescaler ratios in system clock cycles per tick
// ****************************************************************
`define WDT_DIV_LOW    256
`define WDT_DIV_HIGH   16384

// ****************************************************************
// Reset values and counter limits
// ****************************************************************
`define WDT_RELOAD_RST 16'hFF00
`define WDT_RATIO_RST  1'b0
`define WDT_CNT_MAX    16'hFFFF
`define WDT_CNT_ZERO   16'h0000

`endif

/* File: hdl/wdt_pkg.sv */
// Types shared by the watchdog timer modules.
// Assumes the constants header is on the include path.
`include "wdt_params.svh"

package wdt_pkg;

  // ****************************************************************
  // Phase of the watchdog
  // ****************************************************************
  typedef enum logic [1:0] {
    WDT_RUN,
    WDT_PREWARN,
    WDT_RESET
  } wdt_state_e;

  // ****************************************************************
  // Status seen by the core
  // ****************************************************************
  typedef struct packed {
    logic                   enabled;
    logic                   prewarn_phase;
    logic                   ratio_high;
    logic [`WDT_CNT_W-1:0]  reload;
    logic [`WDT_CNT_W-1:0]  count;
  } wdt_status_s;

endpackage

/* File: hdl/wdt_prescaler.sv */
// Prescaler of the watchdog: divides the system clock into one-cycle ticks.
// Assumes run, clear and ratio_high come from logic on the same clock.
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int DIV_LOW  = `WDT_DIV_LOW,
  parameter int DIV_HIGH = `WDT_DIV_HIGH
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic clear,
  input  wire logic ratio_high,
  output logic      tick
);

  logic [`WDT_PRE_W-1:0] cnt_q;
  logic [`WDT_PRE_W-1:0] last;
  logic                  tick_q;

  // Terminal count of a ratio, cut to the counter width.
  function automatic logic [`WDT_PRE_W-1:0] term(input int div);
    term = `WDT_PRE_W'(div - 1);
  endfunction

  // ****************************************************************
  // Divider
  // ****************************************************************

  // The terminal count follows the selected ratio.
  assign last = ratio_high ? term(DIV_HIGH) : term(DIV_LOW);

  // A clear restarts the division so a service grants a whole first tick.
  // A count left above the terminal one by a ratio change wraps at once instead of running the full width.
  always_ff @(posedge mclk) begin
    if (!reset_n || clear) begin
      cnt_q <= '0;
    end else if (run) begin
      cnt_q <= (cnt_q >= last) ? '0 : cnt_q + `WDT_PRE_W'(1);
    end
  end

  // Tick is registered; it trails the terminal count by one cycle.
  always_ff @(posedge mclk) begin
    if (!reset_n || clear) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= run && (cnt_q >= last);
    end
  end

  assign tick = tick_q;

endmodule

/* File: hdl/wdt_top.sv */
// Watchdog timer: a 16-bit up counter fed by a prescaler, steered by the core.
// Assumes the instruction strobes and reload write come from the core on mclk.
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top
  import wdt_pkg::*;
#(
  parameter int DIV_HIGH = `WDT_DIV_HIGH
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  watchdog_disable_instruction,
  input  wire logic                  watchdog_enable_instruction,
  input  wire logic                  watchdog_service_instruction,
  input  wire logic                  reload_write,
  input  wire logic [`WDT_CNT_W-1:0] watchdog_reload_value,
  input  wire logic                  reload_ratio_high,
  output logic                       prewarn_irq,
  output logic                       reset_request,
  output wdt_status_s                status
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wdt_state_e            state_q;
  logic                  enabled_q;
  logic [`WDT_CNT_W-1:0] count_q;
  logic [`WDT_CNT_W-1:0] reload_q;
  logic                  ratio_q;
  logic                  prewarn_irq_q;
  logic                  reset_request_q;
  logic                  prewarn_phase_q;
  logic                  tick;
  logic                  running;
  logic                  service;
  logic                  overflow;

  // ****************************************************************
  // Qualifiers
  // ****************************************************************

  // Counting stops for good once the reset request is out.
  assign running  = enabled_q && (state_q != WDT_RESET);
  // Servicing is refused once the prewarning is given: only a disable instruction can then hold off the reset.
  assign service  = watchdog_service_instruction && (state_q == WDT_RUN);
  assign overflow = running && tick && !service && (count_q == `WDT_CNT_MAX);

  // ****************************************************************
  // Prescaler
  // ****************************************************************

  wdt_prescaler #(
    .DIV_LOW    (`WDT_DIV_LOW),
    .DIV_HIGH   (DIV_HIGH)
  ) u_prescaler (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .run        (running),
    .clear      (service),
    .ratio_high (ratio_q),
    .tick       (tick)
  );

  // ****************************************************************
  // Enable control
  // ****************************************************************

  // disable and enable
  // Disable wins when both strobes meet, the safe reading of a conflict.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enabled_q <= 1'b1;
    end else if (watchdog_disable_instruction) begin
      enabled_q <= 1'b0;
    end else if (watchdog_enable_instruction) begin
      enabled_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Reload register and ratio
  // ****************************************************************

  // full range
  // The default pair gives 256 ticks of 256 clocks, 65536 clocks in all.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reload_q <= `WDT_RELOAD_RST;
      ratio_q  <= `WDT_RATIO_RST;
    end else if (reload_write) begin
      reload_q <= watchdog_reload_value;
      ratio_q  <= reload_ratio_high;
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************

  // service reload
  // A new reload value takes effect at the next service, not at once.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_q <= `WDT_RELOAD_RST;
    end else if (service) begin
      count_q <= reload_q;
    end else if (running && tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Overflow sequence
  // ****************************************************************

  // prewarning then reset
  // The prewarning phase runs a whole wrap from zero before the reset request.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= WDT_RUN;
    end else if (overflow) begin
      unique case (state_q)
        WDT_RUN:     state_q <= WDT_PREWARN;
        WDT_PREWARN: state_q <= WDT_RESET;
        WDT_RESET:   state_q <= WDT_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prewarn_irq_q <= 1'b0;
    end else begin
      prewarn_irq_q <= overflow && (state_q == WDT_RUN);
    end
  end

  // reset request held
  // The request holds until the system reset comes back to this block.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reset_request_q <= 1'b0;
    end else if (overflow && (state_q == WDT_PREWARN)) begin
      reset_request_q <= 1'b1;
    end
  end

  // prewarning phase flag
  // Kept as its own flip-flop so the status output is never a decode of the state register.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prewarn_phase_q <= 1'b0;
    end else if (overflow) begin
      prewarn_phase_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every field is a flip-flop of this module.
  assign prewarn_irq          = prewarn_irq_q;
  assign reset_request        = reset_request_q;
  assign status.enabled       = enabled_q;
  assign status.prewarn_phase = prewarn_phase_q;
  assign status.ratio_high    = ratio_q;
  assign status.reload        = reload_q;
  assign status.count         = count_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  sequence first_overflow_s;
    overflow && (state_q == WDT_RUN);
  endsequence

  sequence second_overflow_s;
    overflow && (state_q == WDT_PREWARN);
  endsequence

  sequence prewarn_pulse_s;
    prewarn_irq_q ##1 !prewarn_irq_q;
  endsequence

  reset_enabled_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> enabled_q && (state_q == WDT_RUN) && !reset_request_q)
    else $error("watchdog not enabled after reset");

  disable_stops_a: assert property (@(posedge mclk) disable iff (!reset_n)
    watchdog_disable_instruction |=> !enabled_q)
    else $error("disable instruction not honoured");

  enable_resumes_a: assert property (@(posedge mclk) disable iff (!reset_n)
    watchdog_enable_instruction && !watchdog_disable_instruction |=> enabled_q)
    else $error("enable instruction not honoured");

  stopped_frozen_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !enabled_q && !service |=> $stable(count_q))
    else $error("counter moved while disabled");

  prewarn_first_a: assert property (@(posedge mclk) disable iff (!reset_n)
    first_overflow_s |=> prewarn_pulse_s and !reset_request_q)
    else $error("first overflow did not give a lone prewarning");

  reset_after_a: assert property (@(posedge mclk) disable iff (!reset_n)
    second_overflow_s |=> reset_request_q [*3])
    else $error("second overflow did not raise the reset request");

  reset_cause_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_request_q) |-> $past(state_q == WDT_PREWARN) && $past(overflow))
    else $error("reset request without prewarning phase");

  service_reload_a: assert property (@(posedge mclk) disable iff (!reset_n)
    service |=> (count_q == $past(reload_q)) && !tick)
    else $error("service did not reload counter and clear prescaler");

  tick_advance_a: assert property (@(posedge mclk) disable iff (!reset_n)
    running && tick && !service |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not advance by one on a tick");

  reload_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reload_write |=> (reload_q == $past(watchdog_reload_value)) && (ratio_q == $past(reload_ratio_high)))
    else $error("reload register not written");

  default_pair_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> (reload_q == `WDT_RELOAD_RST) && (ratio_q == `WDT_RATIO_RST))
    else $error("default reload or ratio wrong after reset");

  low_spacing_a: assert property (@(posedge mclk) disable iff (!reset_n)
    tick && !ratio_q |=> !tick [*8])
    else $error("ticks too close at the low ratio");

  phase_match_a: assert property (@(posedge mclk) disable iff (!reset_n)
    prewarn_phase_q == (state_q != WDT_RUN))
    else $error("prewarning phase flag disagrees with the state");

endmodule

/* File: dv/wdt_core_model.sv */
// Model of the processor core that executes the watchdog control instructions.
// Assumes the bench calls issue() just after a rising edge of mclk.
`timescale 1ns/1ps

module wdt_core_model #(
  parameter int GAP = 200
) (
  input  wire logic mclk,
  input  wire logic keep_alive,
  output logic      dis_o,
  output logic      en_o,
  output logic      svc_o
);
  logic [2:0] cmd_q = 3'b000;
  logic       auto_q = 1'b0;
  int         gap_cnt = 0;

  // The periodic service is kept apart from issued commands so two processes never share a signal.
  assign {en_o, dis_o} = cmd_q[1:0];
  assign svc_o         = cmd_q[2] | auto_q;

  // One instruction pulse, held up to the edge that takes it; mask is {service, enable, disable}.
  task automatic issue(input logic [2:0] m);
    cmd_q = m;
    @(posedge mclk);
    #1;
    cmd_q = 3'b000;
  endtask

  always @(posedge mclk) begin
    #1;
    auto_q  = keep_alive && (gap_cnt == GAP - 1);
    gap_cnt = (!keep_alive || auto_q) ? 0 : gap_cnt + 1;
  end
endmodule

/* File: dv/test_watchdog_timer.sv */
// Self-checking bench of the watchdog timer with a core model as its driver.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`include "wdt_params.svh"

module test_watchdog_timer;
  import wdt_pkg::*;
  localparam int DIV_HI = 32;
  logic                  mclk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  reload_write;
  logic [`WDT_CNT_W-1:0] reload_value;
  logic                  ratio_high;
  logic                  keep_alive;
  logic                  dis_i;
  logic                  en_i;
  logic                  svc_i;
  logic                  prewarn_irq;
  logic                  reset_request;
  wdt_status_s           status;
  int                    errors = 0;
  int                    tests_run = 0;
  logic [31:0]           rng = 32'h0000_0017;
  logic [31:0]           n;
  logic [15:0]           v;
  logic                  hi;

  always #20 mclk = ~mclk;

  wdt_core_model #(.GAP(200)) u_core (.mclk(mclk), .keep_alive(keep_alive), .dis_o(dis_i), .en_o(en_i), .svc_o(svc_i));

  wdt_top #(.DIV_HIGH(DIV_HI)) u_dut (
    .mclk                         (mclk),
    .reset_n                      (reset_n),
    .watchdog_disable_instruction (dis_i),
    .watchdog_enable_instruction  (en_i),
    .watchdog_service_instruction (svc_i),
    .reload_write                 (reload_write),
    .watchdog_reload_value        (reload_value),
    .reload_ratio_high            (ratio_high),
    .prewarn_irq                  (prewarn_irq),
    .reset_request                (reset_request),
    .status                       (status)
  );

  // ****************************************************************
  // Helpers and compare tasks
  // ****************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Cycles from the service edge to the prewarning pulse: one tick per count to the wrap, plus one.
  function automatic logic [31:0] exp_gap(input logic [15:0] r, input logic h);
    return (32'h0001_0000 - {16'h0000, r}) * (h ? DIV_HI : 256) + 1;
  endfunction

  function automatic wdt_status_s mk(input logic e, input logic p, input logic h,
                                     input logic [15:0] r, input logic [15:0] c);
    return '{enabled: e, prewarn_phase: p, ratio_high: h, reload: r, count: c};
  endfunction

  task automatic step(input int k);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic check_status(input wdt_status_s exp, input string what);
    tests_run++;
    if (status !== exp) begin
      errors++;
      $display("[ERR] %0t %s: status %h, expected %h", $time, what, status, exp);
    end
  endtask

  task automatic check_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %0d, expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic set_reload(input logic [15:0] r, input logic h);
    reload_write = 1'b1;
    reload_value = r;
    ratio_high   = h;
    step(1);
    reload_write = 1'b0;
  endtask

  task automatic wait_prewarn(output logic [31:0] k);
    k = 0;
    while (prewarn_irq !== 1'b1 && k < 70000) begin
      step(1);
      k++;
    end
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    step(10);
    reset_n = 1'b1;
  endtask

  task automatic stop_test;
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang must not outlive the longest expected run of about 74,000 cycles by much.
  initial begin
    repeat (95000) @(posedge mclk);
    errors++;
    stop_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    reload_write = 1'b0;
    reload_value = 16'h0000;
    ratio_high   = 1'b0;
    keep_alive   = 1'b0;
    do_reset();
    check_status(mk(1'b1, 1'b0, 1'b0, 16'hFF00, 16'hFF00), "reset state");
    wait_prewarn(n);
    check_num(n >= 65535 && n <= 65538, 1, "default interval");
    step(1);
    check_status(mk(1'b1, 1'b1, 1'b0, 16'hFF00, 16'h0000), "pulse ends, count wrapped");
    u_core.issue(3'b100);
    check_num(status.count, 16'h0000, "service refused in prewarning");
    do_reset();
    check_status(mk(1'b1, 1'b0, 1'b0, 16'hFF00, 16'hFF00), "second reset");
    // Random reloads near the top keep runs short; a random wait leaves the prescaler part-way.
    for (int i = 0; i < 6; i++) begin
      rng = xorshift(rng);
      v   = (i == 0) ? 16'hFFFF : (16'hFFF8 | {13'h0000, rng[2:0]});
      hi  = (i == 0) ? 1'b0 : rng[3];
      set_reload(v, hi);
      check_num({status.ratio_high, status.reload}, {hi, v}, "reload register");
      step(int'(rng[11:4]));
      u_core.issue(3'b100);
      check_num(status.count, v, "service loads reload");
      wait_prewarn(n);
      check_num(n, exp_gap(v, hi), "interval to prewarning");
      check_num(reset_request, 1'b0, "no reset request at first overflow");
      do_reset();
    end
    set_reload(16'hFFFF, 1'b0);
    u_core.issue(3'b100);
    step(100);
    u_core.issue(3'b001);
    step(600);
    check_status(mk(1'b0, 1'b0, 1'b0, 16'hFFFF, 16'hFFFF), "disabled counter frozen");
    u_core.issue(3'b011);
    check_num(status.enabled, 1'b0, "disable wins over enable");
    step(1);
    u_core.issue(3'b010);
    wait_prewarn(n);
    check_num(n >= 140 && n <= 170, 1, "counting resumes");
    do_reset();
    set_reload(16'hFFFF, 1'b0);
    keep_alive = 1'b1;
    n = 0;
    repeat (3000) begin
      step(1);
      n = n + prewarn_irq;
    end
    keep_alive = 1'b0;
    check_num(n, 0, "serviced watchdog never overflows");
    stop_test();
  end
endmodule
